// ==== core/sdll_pkg.sv ====
/*
  Constants and carrier types for the serial converter latch loader.
  Assumes a single 10 MHz core clock; the serial bit clock is sampled.
*/
package sdll_pkg;

  // ----------------------------------------------------------------
  // Word format
  // ----------------------------------------------------------------
  localparam int          SDLL_WORD_W    = 16;
  localparam logic [15:0] SDLL_MIDCODE   = 16'h0000;
  localparam logic [15:0] SDLL_POS_FULL  = 16'h7fff;
  localparam logic [15:0] SDLL_POS_HALF  = 16'h4000;
  localparam logic [15:0] SDLL_NEG_HALF  = 16'hbfff;
  localparam logic [15:0] SDLL_NEG_FULL  = 16'h8000;
  localparam logic [15:0] SDLL_SHIFT_RST = 16'h0000;
  localparam logic [4:0]  SDLL_CNT_RST   = 5'h00;
  localparam logic [4:0]  SDLL_CNT_FULL  = 5'h10;

  // ----------------------------------------------------------------
  // Port state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SDLL_IDLE  = 3'b001,
    SDLL_SHIFT = 3'b010,
    SDLL_DONE  = 3'b100
  } sdll_state_t;

  // Synchronised serial pins
  typedef struct packed {
    logic bit_clk;
    logic select_n;
    logic data;
    logic clear_n;
  } sdll_pins_t;

endpackage

// ==== core/sdll_loader.sv ====
/*
  Receive side of a three-wire serial port that loads a 16-bit
  twos-complement converter latch, with a clear-to-midscale input.
  Assumes the host keeps each bit-clock phase longer than three
  ref_clk periods, since all pins are sampled by ref_clk.
*/
// Overview of operation
// - Latch code is twos complement, 0000 midscale
// - Select falling starts transfer, resets bit count
// - Shift data MSB first on rising clock
// - Load latch on falling edge after 16th
// - Ignore clocks after update until reselect
// - Select rising early discards word, latch kept
// - Clear low in 16th cycle loads midcode
// - Clear high in 16th cycle loads word
// - Clear release mid-transfer leaves latch alone
// - Clear never disturbs serial shifting
// - Select high ignores clock and data
`timescale 1ns/100ps
module sdll_loader
  import sdll_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        bit_clk,
  input  wire logic        select_n,
  input  wire logic        serial_data_input,
  input  wire logic        clear_to_midscale_n,
  output logic [15:0]      dac_latch_q,
  output logic             latch_update_q,
  output logic             busy
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Pin edges are judged from two synchronised samples, never from meta_q
  function automatic logic sdll_rose(input logic now_lvl, input logic was_lvl);
    return now_lvl & ~was_lvl;
  endfunction

  function automatic logic sdll_fell(input logic now_lvl, input logic was_lvl);
    return ~now_lvl & was_lvl;
  endfunction

  // Closing fall of a full word inside an open transfer
  function automatic logic sdll_closing(input sdll_state_t st,
                                        input logic        fall,
                                        input logic [4:0]  cnt);
    return (st == SDLL_SHIFT) && fall && (cnt == SDLL_CNT_FULL);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  sdll_pins_t  meta_q;
  sdll_pins_t  sync_q;
  sdll_pins_t  prev_q;
  sdll_state_t state_q;
  logic [15:0] shift_q;
  logic [4:0]  count_q;
  logic        clk_rise;
  logic        clk_fall;
  logic        sel_fall;
  logic        sel_high;
  logic [4:0]  rise_seen_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_q <= '{bit_clk: 1'b0, select_n: 1'b1, data: 1'b0, clear_n: 1'b1};
      sync_q <= '{bit_clk: 1'b0, select_n: 1'b1, data: 1'b0, clear_n: 1'b1};
      prev_q <= '{bit_clk: 1'b0, select_n: 1'b1, data: 1'b0, clear_n: 1'b1};
    end else begin
      meta_q <= '{bit_clk: bit_clk, select_n: select_n,
                  data: serial_data_input, clear_n: clear_to_midscale_n};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign clk_rise = sdll_rose(sync_q.bit_clk, prev_q.bit_clk);
  assign clk_fall = sdll_fell(sync_q.bit_clk, prev_q.bit_clk);
  assign sel_fall = sdll_fell(sync_q.select_n, prev_q.select_n);
  assign sel_high = sync_q.select_n;
  assign busy     = (state_q != SDLL_IDLE);

  // ----------------------------------------------------------------
  // Transfer sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= SDLL_IDLE;
    end else if (sel_high) begin
      // early select release abandons the word
      state_q <= SDLL_IDLE;
    end else if (sel_fall) begin
      state_q <= SDLL_SHIFT;
    end else begin
      unique case (state_q)
        SDLL_IDLE: begin
          state_q <= SDLL_IDLE;
        end
        SDLL_SHIFT: begin
          // update on falling edge after 16th rise
          if (sdll_closing(state_q, clk_fall, count_q)) begin
            state_q <= SDLL_DONE;
          end
        end
        SDLL_DONE: begin
          state_q <= SDLL_DONE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Shift register and bit count
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      shift_q <= SDLL_SHIFT_RST;
      count_q <= SDLL_CNT_RST;
    end else if (sel_fall) begin
      count_q <= SDLL_CNT_RST;
    end else if (state_q == SDLL_SHIFT && !sel_high && clk_rise
                 && count_q != SDLL_CNT_FULL) begin
      // msb first; clear plays no part here; gated by select
      shift_q <= {shift_q[14:0], sync_q.data};
      count_q <= count_q + 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // Converter latch
  // ----------------------------------------------------------------
  // Clear is sampled at the closing edge, which falls within the 16th cycle.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dac_latch_q    <= SDLL_MIDCODE;
      latch_update_q <= 1'b0;
    end else if (!sel_high && !sel_fall
                 && sdll_closing(state_q, clk_fall, count_q)) begin
      dac_latch_q    <= sync_q.clear_n ? shift_q : SDLL_MIDCODE;
      latch_update_q <= 1'b1;
    end else begin
      // latch only changes on an update
      latch_update_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  latch_stable_a: assert property (@(posedge ref_clk) disable iff (rst)
    !latch_update_q |-> $stable(dac_latch_q) || $past(latch_update_q) == 1'b0
      && $past(dac_latch_q) == dac_latch_q)
    else $error("latch changed without an update");

  clear_midcode_a: assert property (@(posedge ref_clk) disable iff (rst)
    latch_update_q && !$past(sync_q.clear_n) |-> dac_latch_q == SDLL_MIDCODE)
    else $error("clear did not load midcode");

  word_load_a: assert property (@(posedge ref_clk) disable iff (rst)
    latch_update_q && $past(sync_q.clear_n) |-> dac_latch_q == $past(shift_q))
    else $error("received word not loaded");

  update_count_a: assert property (@(posedge ref_clk) disable iff (rst)
    latch_update_q |-> $past(count_q) == SDLL_CNT_FULL && $past(clk_fall))
    else $error("update before sixteen bits");

  ignore_after_a: assert property (@(posedge ref_clk) disable iff (rst)
    state_q == SDLL_DONE && !sel_high && !sel_fall |=> !latch_update_q)
    else $error("clock edges not ignored after update");

  select_abort_a: assert property (@(posedge ref_clk) disable iff (rst)
    sel_high |=> state_q == SDLL_IDLE ##1 !latch_update_q)
    else $error("select release did not abort");

  select_start_a: assert property (@(posedge ref_clk) disable iff (rst)
    sel_fall |=> count_q == SDLL_CNT_RST && state_q == SDLL_SHIFT)
    else $error("select falling did not restart");

  shift_msb_a: assert property (@(posedge ref_clk) disable iff (rst)
    state_q == SDLL_SHIFT && !sel_high && !sel_fall && clk_rise
      && count_q != SDLL_CNT_FULL
      |=> shift_q[0] == $past(sync_q.data) && shift_q[15:1] == $past(shift_q[14:0]))
    else $error("shift not msb first");

  idle_quiet_a: assert property (@(posedge ref_clk) disable iff (rst)
    sel_high && $past(sel_high) |=> $stable(shift_q) && !latch_update_q)
    else $error("activity while deselected");

  // ----------------------------------------------------------------
  // Transfer and clear checks
  // ----------------------------------------------------------------
  word_kept_a: assert property (@(posedge ref_clk) disable iff (rst)
    state_q == SDLL_SHIFT && sel_high |=> $stable(dac_latch_q))
    else $error("partial word reached the latch");

  busy_drop_a: assert property (@(posedge ref_clk) disable iff (rst)
    sel_high |=> !busy && !latch_update_q)
    else $error("transfer still open after select release");

  busy_rise_a: assert property (@(posedge ref_clk) disable iff (rst)
    sel_fall |=> busy)
    else $error("select falling did not open a transfer");

  busy_done_a: assert property (@(posedge ref_clk) disable iff (rst)
    latch_update_q |-> busy)
    else $error("port left the transfer at the update");

  data_ignored_a: assert property (@(posedge ref_clk) disable iff (rst)
    sel_high && sync_q.data != prev_q.data |=> $stable(shift_q) && $stable(count_q))
    else $error("data taken while deselected");

  idle_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    state_q == SDLL_IDLE && !sel_fall |=> $stable(shift_q) && $stable(count_q))
    else $error("shifter moved outside a transfer");

  done_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    state_q == SDLL_DONE && !sel_fall |=> $stable(shift_q) && $stable(count_q))
    else $error("shifter moved after the update");

  count_limit_a: assert property (@(posedge ref_clk) disable iff (rst)
    count_q == SDLL_CNT_FULL && clk_rise && !sel_fall
      |=> $stable(shift_q) && $stable(count_q))
    else $error("bit after the sixteenth was shifted");

  count_bound_a: assert property (@(posedge ref_clk) disable iff (rst)
    count_q <= SDLL_CNT_FULL)
    else $error("bit count past sixteen");

  update_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
    latch_update_q |=> !latch_update_q)
    else $error("update pulse longer than one cycle");

  update_source_a: assert property (@(posedge ref_clk) disable iff (rst)
    latch_update_q |-> $past(state_q) == SDLL_SHIFT && state_q == SDLL_DONE)
    else $error("update outside an open transfer");

  // The clear pin may move at any time; only the closing fall reads it
  clear_shift_a: assert property (@(posedge ref_clk) disable iff (rst)
    state_q == SDLL_SHIFT && !sel_high && !sel_fall && clk_rise
      && count_q != SDLL_CNT_FULL && !sync_q.clear_n
      |=> count_q == $past(count_q) + 5'h01)
    else $error("clear disturbed serial shifting");

  clear_edge_a: assert property (@(posedge ref_clk) disable iff (rst)
    sync_q.clear_n != prev_q.clear_n && !clk_rise && !sel_fall
      |=> $stable(count_q) && $stable(shift_q))
    else $error("clear edge moved the shifter");

  clear_release_a: assert property (@(posedge ref_clk) disable iff (rst)
    sync_q.clear_n && !prev_q.clear_n && !sdll_closing(state_q, clk_fall, count_q)
      |=> $stable(dac_latch_q) && !latch_update_q)
    else $error("clear release changed the latch");

  clear_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    !sync_q.clear_n && !sdll_closing(state_q, clk_fall, count_q)
      |=> $stable(dac_latch_q))
    else $error("clear alone changed the latch");

  state_legal_a: assert property (@(posedge ref_clk) disable iff (rst)
    $onehot(state_q))
    else $error("port state not one-hot");

  // Written without a disable so that the reset values themselves are checked
  reset_state_a: assert property (@(posedge ref_clk)
    rst |=> dac_latch_q == SDLL_MIDCODE && shift_q == SDLL_SHIFT_RST
      && count_q == SDLL_CNT_RST && state_q == SDLL_IDLE && !latch_update_q)
    else $error("reset state wrong");

  // ----------------------------------------------------------------
  // Independent rise count for the checks
  // ----------------------------------------------------------------
  // Counted apart from count_q so the update checks do not lean on the
  // logic they guard; saturates rather than wrapping past 31.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rise_seen_q <= SDLL_CNT_RST;
    end else if (sel_fall) begin
      rise_seen_q <= SDLL_CNT_RST;
    end else if (!sel_high && clk_rise && rise_seen_q != 5'h1f) begin
      rise_seen_q <= rise_seen_q + 5'h01;
    end
  end

  rise_total_a: assert property (@(posedge ref_clk) disable iff (rst)
    latch_update_q |-> $past(rise_seen_q) == SDLL_CNT_FULL)
    else $error("update after a wrong number of rises");

  count_track_a: assert property (@(posedge ref_clk) disable iff (rst)
    state_q == SDLL_SHIFT |-> count_q == rise_seen_q)
    else $error("bit count lost a rise");

endmodule

// ==== verif/sdll_host.sv ====
/*
  Host model driving the three-wire serial port of the latch loader.
  Assumes a 100 ns ref_clk; each bit-clock phase lasts four ref_clk periods.
*/
`timescale 1ns/100ps
module sdll_host (
  input  wire logic ref_clk,
  output logic      bit_clk,
  output logic      select_n,
  output logic      data,
  output logic      clear_n
);
  initial begin
    bit_clk = 1'b0;
    select_n = 1'b1;
    data = 1'b0;
    clear_n = 1'b1;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic pulse(input logic d);
    data <= d;
    wait_clk(4);
    bit_clk <= 1'b1;
    wait_clk(4);
    bit_clk <= 1'b0;
  endtask

  task automatic send(input logic [15:0] w, input int n, input logic cm,
                      input logic ce, input logic junk);
    select_n <= 1'b0;
    clear_n <= ~cm;
    wait_clk(4);
    for (int i = 0; i < n; i++) begin
      if (i == 15)
        clear_n <= ~ce;
      pulse(w[15-i]);
    end
    wait_clk(4);
    if (junk)
      pulse(~w[0]);
    select_n <= 1'b1;
    clear_n <= 1'b1;
    // Released line must not keep the last bit
    data <= ~data;
    wait_clk(4);
    if (junk)
      pulse(w[0]);
    wait_clk(4);
  endtask
endmodule

// ==== verif/tb.sv ====
/*
  Self-checking bench for the latch loader with a behavioural model.
  Assumes the host model in sdll_host and a 10 MHz ref_clk.
*/
`timescale 1ns/100ps
module tb;
  import sdll_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst;
  logic        bit_clk, select_n, sdata, clear_n, upd, busy, cm, ce, jk;
  logic [15:0] latch, w, exp_latch;
  logic [31:0] r;
  logic [15:0] codes [$];
  int          err_total, samples_checked, pulses, exp_pulses, cycles, n, busy_seen;
  int          seed = 72943;

  sdll_host host_u (.ref_clk(ref_clk), .bit_clk(bit_clk), .select_n(select_n),
                    .data(sdata), .clear_n(clear_n));
  sdll_loader dut_u (.ref_clk(ref_clk), .rst(rst), .bit_clk(bit_clk),
                     .select_n(select_n), .serial_data_input(sdata),
                     .clear_to_midscale_n(clear_n), .dac_latch_q(latch),
                     .latch_update_q(upd), .busy(busy));

  initial forever #50 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cycles++;
    if (upd === 1'b1)
      pulses++;
    if (busy === 1'b1)
      busy_seen++;
    // Far above the ~4000 cycles the run needs
    if (cycles == 20000) begin
      err_total++;
      end_sim();
    end
  end

  task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (e !== g) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    rst <= 1'b1;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    exp_latch = SDLL_MIDCODE;
    check("latch", exp_latch, latch);
    codes = '{SDLL_POS_FULL, SDLL_POS_HALF, SDLL_MIDCODE, SDLL_NEG_HALF, SDLL_NEG_FULL};
    for (int k = 0; k < 30; k++) begin
      r = $random(seed);
      w = (k < 5) ? codes[k] : r[31:16];
      n = (k < 5 || k % 3 != 0) ? 16 : 1 + int'(r[6:3]) % 15;
      cm = (k >= 5) & r[0];
      ce = (k >= 5) & r[1];
      jk = r[2] & (n == 16);
      host_u.send(w, n, cm, ce, jk);
      if (n == 16) begin
        exp_latch = ce ? SDLL_MIDCODE : w;
        exp_pulses++;
      end
      check("latch", exp_latch, latch);
      check("pulses", 16'(exp_pulses), 16'(pulses));
      check("busy", 16'h0000, {15'h0000, busy});
    end
    check("busy seen", 16'h0001, {15'h0000, busy_seen > 0});
    end_sim();
  end
endmodule
